// ==== design/lsm_top.sv ====
`timescale 1ns/1ps
module lsm_top
	import lsm_pkg::*;
#(
	parameter int BLINK_HALF = BLINK_HALF_CYC,
	parameter int STRETCH    = STRETCH_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	input  wire logic              link_up_i,
	input  wire logic              tx_act_i,
	input  wire logic              rx_act_i,
	input  wire logic              col_i,
	input  wire logic              speed100_i,
	input  wire logic              full_duplex_i,
	input  wire logic              lpi_i,
	input  wire logic              tx_err_i,
	input  wire logic              rx_err_i,
	input  wire logic              tp_err_i,
	output logic      [2:0]        led_o,
	output logic                   mac_slew_slow_o,
	output logic                   irq_o
);

	localparam int BW = $clog2(BLINK_HALF + 1);
	localparam int SW = $clog2(STRETCH + 1);

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		merge16 = old;
		if (sel[0])
			merge16[7:0] = wd[7:0];
		if (sel[1])
			merge16[15:8] = wd[15:8];
	endfunction

	logic [15:0]      led_src;
	logic [15:0]      pin_slew;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [15:0]      tp_count;
	logic             link_lost;
	logic             tp_latch;
	logic             link_prev;
	logic [BW-1:0]    blink_cnt;
	logic             blink_phase;
	logic [SW-1:0]    str_cnt;

	// bus decode
	wire        access   = cyc_i & stb_i & ~ack_o;
	wire        wr       = access & we_i;
	wire        rd       = access & ~we_i;
	wire [11:0] idx      = adr_i[13:2];
	wire        hit_ls   = idx == IDX_LINK_STATUS;
	wire        hit_led  = idx == IDX_LED_SRC;
	wire        hit_slew = idx == IDX_PIN_SLEW;
	wire        hit_ist  = idx == IDX_IRQ_STATUS;
	wire        hit_imk  = idx == IDX_IRQ_MASK;
	wire        hit_tpc  = idx == IDX_TP_COUNT;
	wire        rd_ls    = rd & hit_ls;
	wire        rd_ist   = rd & hit_ist;
	wire        tp_clear = wr & hit_tpc;

	wire [15:0] led_wr   = merge16(led_src, dat_i, sel_i);
	wire [15:0] next_led = {FIRST_RST, led_wr[11:0]};

	// events
	wire link_drop = link_prev & ~link_up_i;
	wire if_err    = tx_err_i | rx_err_i;
	wire [IRQ_W-1:0] evt = {if_err, tp_err_i, link_drop};

	wire [15:0] ls_val = 16'(({15'h0000, link_up_i} << LS_UP_BIT)
		| ({15'h0000, link_lost} << LS_LOST_BIT));

	wire [15:0] rd_val =
		hit_ls   ? ls_val :
		hit_led  ? led_src :
		hit_slew ? pin_slew :
		hit_ist  ? {{(16-IRQ_W){1'b0}}, irq_stat} :
		hit_imk  ? {{(16-IRQ_W){1'b0}}, irq_mask} :
		hit_tpc  ? tp_count : 16'h0000;

	// activity stretch and blink timer
	wire act_any = tx_act_i | rx_act_i;
	wire act_str = act_any | (str_cnt != '0);
	wire blink_wrap = blink_cnt == BW'(BLINK_HALF - 1);

	// source table, index by code
	wire [15:0] cond;
	assign cond[SRC_LINK]     = link_up_i;
	assign cond[SRC_ACT]      = act_any;
	assign cond[SRC_TX]       = tx_act_i;
	assign cond[SRC_RX]       = rx_act_i;
	assign cond[SRC_COL]      = col_i;
	assign cond[SRC_SPD100]   = speed100_i;
	assign cond[SRC_SPD10]    = ~speed100_i;
	assign cond[SRC_FDX]      = full_duplex_i;
	assign cond[SRC_LINKBLK]  = link_up_i & (~act_str | blink_phase);
	assign cond[SRC_STRETCH]  = act_str;
	assign cond[SRC_FD100]    = speed100_i & full_duplex_i;
	assign cond[SRC_LPI]      = lpi_i;
	assign cond[SRC_IFERR]    = if_err;
	assign cond[SRC_LOST]     = link_lost;
	assign cond[SRC_TPERR]    = tp_latch;
	assign cond[SRC_RESERVED] = 1'b0;

	wire [3:0] code1 = led_src[FIRST_LSB +: SRC_W];
	wire [3:0] code2 = led_src[SECOND_LSB +: SRC_W];
	wire [3:0] code3 = led_src[THIRD_LSB +: SRC_W];
	wire [2:0] next_led_o = {cond[code3], cond[code2], cond[code1]};

	// bus slave
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= access;
			dat_o <= rd ? {16'h0000, rd_val} : 32'h0000_0000;
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_src  <= LED_SRC_RST;
			pin_slew <= PIN_SLEW_RST;
			irq_mask <= '0;
		end else if (wr) begin
			if (hit_led)
				led_src <= next_led;
			if (hit_slew)
				pin_slew <= merge16(pin_slew, dat_i, sel_i);
			if (hit_imk & sel_i[0])
				irq_mask <= dat_i[IRQ_W-1:0];
		end
	end

	// sticky indications; a new event wins over a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_prev <= 1'b0;
			link_lost <= 1'b0;
			tp_latch  <= 1'b0;
			tp_count  <= 16'h0000;
			irq_stat  <= '0;
		end else begin
			link_prev <= link_up_i;
			link_lost <= link_drop | (link_lost & ~rd_ls);
			tp_latch  <= tp_err_i | (tp_latch & ~tp_clear);
			if (tp_clear)
				tp_count <= tp_err_i ? 16'h0001 : 16'h0000;
			else if (tp_err_i && tp_count != 16'hFFFF)
				tp_count <= tp_count + 16'h0001;
			irq_stat <= evt | (irq_stat & ~{IRQ_W{rd_ist}});
		end
	end

	// timers and outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt   <= '0;
			blink_phase <= 1'b0;
			str_cnt     <= '0;
			led_o       <= 3'b000;
			irq_o       <= 1'b0;
		end else begin
			blink_cnt   <= blink_wrap ? '0 : blink_cnt + BW'(1);
			blink_phase <= blink_phase ^ blink_wrap;
			if (act_any)
				str_cnt <= SW'(STRETCH);
			else if (str_cnt != '0)
				str_cnt <= str_cnt - SW'(1);
			led_o <= next_led_o;
			irq_o <= |((evt | (irq_stat & ~{IRQ_W{rd_ist}})) & irq_mask);
		end
	end

	assign mac_slew_slow_o = pin_slew[SLEW_BIT];

	// checks
	a_first_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		led_src[FIRST_LSB +: SRC_W] == FIRST_RST)
		else $error("first source field changed");

	sequence s_led_wr(int lane);
		wr && hit_led && sel_i[lane];
	endsequence

	a_second_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_led_wr(1) |=> code2 == $past(dat_i[11:8]))
		else $error("second source write lost");

	a_third_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_led_wr(0) |=> code3 == $past(dat_i[7:4]))
		else $error("third source write lost");

	a_code_link: assert property (@(posedge clk_i) disable iff (rst_i)
		code2 == SRC_LINK |=> led_o[1] == $past(link_up_i))
		else $error("link source not shown");

	a_blink_down: assert property (@(posedge clk_i) disable iff (rst_i)
		code3 == SRC_LINKBLK && !link_up_i |=> !led_o[2])
		else $error("blink led lit without link");

	a_fd100_src: assert property (@(posedge clk_i) disable iff (rst_i)
		code2 == SRC_FD100 |=>
			led_o[1] == $past(speed100_i & full_duplex_i))
		else $error("fd100 source wrong");

	a_lost_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		link_lost && !rd_ls |=> link_lost [*1] ##1 1'b1)
		else $error("link lost dropped without read");

	a_lost_set: assert property (@(posedge clk_i) disable iff (rst_i)
		link_prev && !link_up_i |=> link_lost)
		else $error("link drop not latched");

	a_tp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		tp_latch && !tp_clear |=> tp_latch)
		else $error("test error indication lost");

	a_slew_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_slew && sel_i[0] |=> mac_slew_slow_o == $past(dat_i[0]))
		else $error("slew select not applied");

	a_reserved_off: assert property (@(posedge clk_i) disable iff (rst_i)
		code3 == SRC_RESERVED |=> !led_o[2])
		else $error("reserved code lit led");

	a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held two cycles");

endmodule // lsm_top

// ==== include/lsm_pkg.sv ====
package lsm_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_LINK_STATUS = 12'h001;
	localparam logic [11:0] IDX_LED_SRC     = 12'h460;
	localparam logic [11:0] IDX_PIN_SLEW    = 12'h461;
	localparam logic [11:0] IDX_IRQ_STATUS  = 12'h470;
	localparam logic [11:0] IDX_IRQ_MASK    = 12'h471;
	localparam logic [11:0] IDX_TP_COUNT    = 12'h472;
	localparam int          ADDR_W          = 16;

	// led_source_select fields
	localparam int FIRST_LSB  = 12;
	localparam int SECOND_LSB = 8;
	localparam int THIRD_LSB  = 4;
	localparam int SRC_W      = 4;
	localparam logic [15:0] LED_SRC_RST  = 16'h5665;
	localparam logic [3:0]  FIRST_RST    = 4'h5;
	localparam logic [15:0] PIN_SLEW_RST = 16'h0010;
	localparam int          SLEW_BIT     = 0;

	// link status register bits
	localparam int LS_LOST_BIT = 1;
	localparam int LS_UP_BIT   = 2;

	// interrupt bits, shared by status and mask
	localparam int IRQ_W        = 3;
	localparam int IRQ_LOST_BIT = 0;
	localparam int IRQ_TP_BIT   = 1;
	localparam int IRQ_ERR_BIT  = 2;

	// source codes
	localparam logic [3:0] SRC_LINK     = 4'h0;
	localparam logic [3:0] SRC_ACT      = 4'h1;
	localparam logic [3:0] SRC_TX       = 4'h2;
	localparam logic [3:0] SRC_RX       = 4'h3;
	localparam logic [3:0] SRC_COL      = 4'h4;
	localparam logic [3:0] SRC_SPD100   = 4'h5;
	localparam logic [3:0] SRC_SPD10    = 4'h6;
	localparam logic [3:0] SRC_FDX      = 4'h7;
	localparam logic [3:0] SRC_LINKBLK  = 4'h8;
	localparam logic [3:0] SRC_STRETCH  = 4'h9;
	localparam logic [3:0] SRC_FD100    = 4'hA;
	localparam logic [3:0] SRC_LPI      = 4'hB;
	localparam logic [3:0] SRC_IFERR    = 4'hC;
	localparam logic [3:0] SRC_LOST     = 4'hD;
	localparam logic [3:0] SRC_TPERR    = 4'hE;
	localparam logic [3:0] SRC_RESERVED = 4'hF;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BLINK_HALF_NS = 50000000;
	localparam int STRETCH_NS    = 50000000;
	localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
	localparam int STRETCH_CYC    = STRETCH_NS / CLK_PERIOD_NS;
endpackage

// ==== tb/lsm_led_model.sv ====
`timescale 1ns/1ps
// far-side indicators: counts how often each lamp lights up
module lsm_led_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] led_i,
	output int              lit_cnt_o [3]
);
	logic [2:0] prev;
	always_ff @(posedge clk_i) begin
		prev <= rst_i ? 3'h0 : led_i;
		for (int i = 0; i < 3; i++) begin
			if (rst_i)
				lit_cnt_o[i] <= 0;
			else if (led_i[i] && !prev[i])
				lit_cnt_o[i] <= lit_cnt_o[i] + 1;
		end
	end
endmodule // lsm_led_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	import lsm_pkg::*;
	localparam logic [8:0] PATS [3] = '{9'h000, 9'h155, 9'h0AA};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tp = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] dat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [8:0]  lv = 9'h000;
	logic [31:0] dat_o;
	logic        ack_o, mac_slew_slow_o, irq_o;
	logic [2:0]  led_o;
	logic [15:0] q;
	int          lit_cnt [3];
	int          err_count = 0, num_checks = 0;
	int          lit_base;
	logic [1:0]  seen;
	always #5 clk_i = ~clk_i;
	lsm_top #(.BLINK_HALF(4), .STRETCH(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .link_up_i(lv[0]),
		.tx_act_i(lv[1]), .rx_act_i(lv[2]), .col_i(lv[3]),
		.speed100_i(lv[4]), .full_duplex_i(lv[5]), .lpi_i(lv[6]),
		.tx_err_i(lv[7]), .rx_err_i(lv[8]), .tp_err_i(tp), .led_o(led_o),
		.mac_slew_slow_o(mac_slew_slow_o), .irq_o(irq_o));
	lsm_led_model leds (.clk_i(clk_i), .rst_i(rst_i), .led_i(led_o),
		.lit_cnt_o(lit_cnt));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; data taken at the edge that samples ack
	task automatic wb(input logic w, input logic [15:0] a,
			input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3;
		dat <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			err_count++;
			end_sim();
		end
		q = dat_o[15:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic expf(input logic [3:0] c, input logic [8:0] v);
		case (c)
			4'h0: return v[0];
			4'h1: return v[1] | v[2];
			4'h2: return v[1];
			4'h3: return v[2];
			4'h4: return v[3];
			4'h5: return v[4];
			4'h6: return ~v[4];
			4'h7: return v[5];
			4'hA: return v[4] & v[5];
			4'hB: return v[6];
			4'hC: return v[7] | v[8];
			default: return 1'b0;
		endcase
	endfunction
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 16'h1180, 16'h0000);
		chk("led_source_select", 16'h5665, q);
		wb(1'b0, 16'h1184, 16'h0000);
		chk("pin_slew_control", 16'h0010, q);
		chk("slew pin", 16'h0000, {15'h0, mac_slew_slow_o});
		wb(1'b1, 16'h1184, 16'h0011);
		chk("slew pin", 16'h0001, {15'h0, mac_slew_slow_o});
		wb(1'b1, 16'h1180, 16'h0A95);
		wb(1'b0, 16'h1180, 16'h0000);
		chk("led_source_select", 16'h5A95, q);
		wb(1'b0, 16'h0F00, 16'h0000);
		chk("unmapped read", 16'h0000, q);
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			if (!(c inside {8, 9, 13, 14})) begin
				for (int p = 0; p < 3; p++) begin
					wb(1'b1, 16'h1180, {4'h0, c[3:0], c[3:0], 4'h0});
					lv <= PATS[p];
					repeat (3) @(posedge clk_i);
					chk("second led", {15'h0, expf(c[3:0], PATS[p])},
						{15'h0, led_o[1]});
					chk("third led", {15'h0, expf(c[3:0], PATS[p])},
						{15'h0, led_o[2]});
					chk("first led", {15'h0, PATS[p][4]}, {15'h0, led_o[0]});
				end
			end
		end
		$display("test source codes done");
		lv <= 9'h001;
		wb(1'b1, 16'h1180, 16'h00D0);
		wb(1'b0, 16'h0004, 16'h0000);
		wb(1'b1, 16'h11C4, 16'h0001);
		wb(1'b0, 16'h11C0, 16'h0000);
		lv <= 9'h000;
		repeat (3) @(posedge clk_i);
		chk("third led lost", 16'h0001, {15'h0, led_o[2]});
		chk("irq", 16'h0001, {15'h0, irq_o});
		wb(1'b0, 16'h0004, 16'h0000);
		chk("lost bit", 16'h0001, {15'h0, q[1]});
		wb(1'b0, 16'h11C0, 16'h0000);
		chk("irq status", 16'h0001, q & 16'h0001);
		repeat (2) @(posedge clk_i);
		chk("third led lost", 16'h0000, {15'h0, led_o[2]});
		chk("irq", 16'h0000, {15'h0, irq_o});
		$display("test link lost done");
		wb(1'b1, 16'h1180, 16'h00E0);
		lit_base = lit_cnt[2];
		tp <= 1'b1;
		@(posedge clk_i);
		tp <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("third led tp", 16'h0001, {15'h0, led_o[2]});
		wb(1'b0, 16'h11C8, 16'h0000);
		chk("tp count", 16'h0001, q);
		wb(1'b1, 16'h11C8, 16'h0000);
		repeat (2) @(posedge clk_i);
		chk("third led tp", 16'h0000, {15'h0, led_o[2]});
		chk("lamp lights", 16'(lit_base + 1), 16'(lit_cnt[2]));
		$display("test pattern error done, lamp lit %0d", lit_cnt[2]);
		// second led link/blink, third led stretched activity
		lv <= 9'h001;
		wb(1'b1, 16'h1180, 16'h0890);
		repeat (2) @(posedge clk_i);
		chk("second led blink", 16'h0001, {15'h0, led_o[1]});
		chk("third led stretch", 16'h0000, {15'h0, led_o[2]});
		lv <= 9'h003;
		seen = 2'b00;
		repeat (10) begin
			@(posedge clk_i);
			seen = seen | {led_o[1], ~led_o[1]};
		end
		chk("blink phases", 16'h0003, {14'h0, seen});
		chk("third led stretch", 16'h0001, {15'h0, led_o[2]});
		lv <= 9'h001;
		repeat (4) @(posedge clk_i);
		chk("third led stretch", 16'h0001, {15'h0, led_o[2]});
		repeat (8) @(posedge clk_i);
		chk("third led stretch", 16'h0000, {15'h0, led_o[2]});
		chk("second led blink", 16'h0001, {15'h0, led_o[1]});
		$display("test blink and stretch done");
		end_sim();
	end
endmodule // tb
